//--- rtl/pin_wake_map.vh
`ifndef PIN_WAKE_MAP_VH
`define PIN_WAKE_MAP_VH
// number of general-purpose bidirectional pins (positions 0..18)
`define GP_PIN_COUNT      19
// number of output-only pins
`define OUT_PIN_COUNT     2
// reset values
`define WAKE_EN_RESET     19'h00000
`define EDGE_RISE_RESET   19'h7ffff
`define DRIVE_RESET       2'h3
`define PULLUP_RESET      2'h3
// bit positions inside the output-only masks
`define OUT_PIN_ZERO_BIT  0
`define OUT_PIN_ONE_BIT   1
// extra event flags appended above the pin bits in the status word
`define STATUS_EXTRA_BITS 2
`endif

//--- rtl/pin_edge_detect.v
`timescale 1ns/1ps
`include "pin_wake_map.vh"
module pin_edge_detect #(
    parameter WIDTH = `GP_PIN_COUNT
) (
    // clock and reset
    input  wire             clock_in,
    input  wire             nrst_in,
    // raw asynchronous pins and edge choice
    input  wire [WIDTH-1:0] pin_in,
    input  wire [WIDTH-1:0] rise_sel_in,
    // synchronised level and edge pulse
    output wire [WIDTH-1:0] level_out,
    output wire [WIDTH-1:0] edge_out
);
    reg [WIDTH-1:0] sync1_q;
    reg [WIDTH-1:0] sync2_q;
    reg [WIDTH-1:0] prev_q;
    reg [2:0]       fill_q;

    // two-stage synchroniser; prev holds last settled level
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            sync1_q  <= {WIDTH{1'b0}};
            sync2_q  <= {WIDTH{1'b0}};
            prev_q   <= {WIDTH{1'b0}};
            fill_q   <= 3'h0;
        end else begin
            sync1_q  <= pin_in;
            sync2_q  <= sync1_q;
            prev_q   <= sync2_q;
            fill_q   <= {fill_q[1:0], 1'b1};
        end
    end

    // no edge until prev holds a real pin level; a high idle pad
    // would otherwise look like a rising edge right after reset
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_edge
            assign edge_out[i] = fill_q[2] & (rise_sel_in[i] ? (sync2_q[i] & ~prev_q[i])
                                                            : (~sync2_q[i] & prev_q[i]));
        end
    endgenerate
    assign level_out = sync2_q;
endmodule

//--- rtl/pin_wake_and_output_ctrl.v
`timescale 1ns/1ps
`include "pin_wake_map.vh"
// Summary of operation
// [RULE_01] - enable mask sets, disable mask clears wake
// [RULE_02] - bits clear in both masks keep state
// [RULE_03] - both masks set means wake disabled
// [RULE_04] - edge masks; rising default and wins ties
// [RULE_05] - enable/edge writes ignore non-input pins
// [RULE_06] - peripheral-owned input pins still take settings
// [RULE_07] - wake settings held through sleep
// [RULE_08] - wake and interrupt views share storage
// [RULE_09] - status read returns flags, then clears all
// [RULE_10] - unused status bits always read zero
// [RULE_11] - deep sleep wake leaves status empty
// [RULE_12] - normal sleep wake accumulates boot events
// [RULE_13] - route bit maps radio signals onto pins
// [RULE_14] - enabled outputs block spi and diversity drive
// [RULE_15] - enable request fails while spi owns pins
// [RULE_16] - reset/sleep/wake release output pins, pull-ups on
// [RULE_17] - high mask drives high, low mask low
// [RULE_18] - output pins high after power-up
// [RULE_19] - both masks low; neither keeps level
// [RULE_20] - drive write waits until peripheral disabled
// [RULE_21] - reset clears all wake and interrupt enables
// [RULE_22] - masks cover pin positions 0 to 18
// [RULE_23] - selected edge sets status, requests wake
module pin_wake_and_output_ctrl #(
    parameter NPIN = `GP_PIN_COUNT
) (
    // clock and reset
    input  wire                 clock_in,
    input  wire                 nrst_in,
    // pin configuration from the direction and mux logic
    input  wire [NPIN-1:0]      pin_is_input_in,
    input  wire [NPIN-1:0]      pin_periph_owned_in,
    // wake/interrupt enable write, shared by both views
    input  wire                 wake_en_wr_in,
    input  wire [NPIN-1:0]      wake_set_mask_in,
    input  wire [NPIN-1:0]      wake_clear_mask_in,
    // edge select write, shared by both views
    input  wire                 edge_wr_in,
    input  wire [NPIN-1:0]      rising_edge_mask_in,
    input  wire [NPIN-1:0]      falling_edge_mask_in,
    // status read strobe and extra pin event sources
    input  wire                 status_rd_in,
    input  wire [`STATUS_EXTRA_BITS-1:0] other_event_in,
    // power state from the system controller
    input  wire                 sleep_in,
    // bidirectional pin levels (asynchronous)
    input  wire [NPIN-1:0]      bidir_gp_pin_in,
    // radio and modem interface routing
    input  wire                 route_wr_in,
    input  wire                 rf_signal_route_en_in,
    input  wire [NPIN-1:0]      rf_out_in,
    input  wire [NPIN-1:0]      rf_oe_n_in,
    input  wire [NPIN-1:0]      gp_out_in,
    input  wire [NPIN-1:0]      gp_oe_n_in,
    // output-only pin control
    input  wire                 out_en_wr_in,
    input  wire                 out_en_val_in,
    input  wire                 spi_master_active_in,
    input  wire [`OUT_PIN_COUNT-1:0] spi_drive_in,
    input  wire [`OUT_PIN_COUNT-1:0] diversity_drive_in,
    input  wire                 drive_wr_in,
    input  wire [`OUT_PIN_COUNT-1:0] drive_high_mask_in,
    input  wire [`OUT_PIN_COUNT-1:0] drive_low_mask_in,
    input  wire [`OUT_PIN_COUNT-1:0] out_periph_en_in,
    // wake status and request
    output reg  [31:0]          status_data_out,
    output wire                 wake_req_out,
    output wire [NPIN-1:0]      wake_en_out,
    output wire [NPIN-1:0]      edge_rising_out,
    // bidirectional pin drive
    output reg  [NPIN-1:0]      bidir_gp_pin_out,
    output reg  [NPIN-1:0]      bidir_gp_pin_oe_n_out,
    output wire                 rf_signal_route_en_out,
    // output-only pins
    output wire                 output_only_pin_zero_out,
    output wire                 output_only_pin_one_out,
    output wire [`OUT_PIN_COUNT-1:0] out_pullup_en_out,
    output wire                 out_gp_enabled_out,
    output reg                  out_en_ack_out,
    output reg                  out_en_ok_out
);
    localparam NSTAT = NPIN + `STATUS_EXTRA_BITS;

    // wake enables and edge choice: one storage for wake and interrupt views [RULE_08]
    reg  [NPIN-1:0]  wake_en_q;
    reg  [NPIN-1:0]  wake_en_d;
    reg  [NPIN-1:0]  rise_q;
    reg  [NPIN-1:0]  rise_d;
    reg  [NSTAT-1:0] status_q;
    reg  [NSTAT-1:0] status_d;
    reg              route_q;
    reg              out_gp_en_q;
    reg  [`OUT_PIN_COUNT-1:0] drive_q;
    reg  [`OUT_PIN_COUNT-1:0] pend_hi_q;
    reg  [`OUT_PIN_COUNT-1:0] pend_lo_q;
    // pending drive values wait above while a peripheral owns the pin
    reg              sleep_s1_q;
    reg              sleep_s2_q;
    reg              sleep_prev_q;
    wire [NPIN-1:0]  pin_edge;
    wire [NPIN-1:0]  writable;
    wire [NPIN-1:0]  pin_event;
    wire [NSTAT-1:0] new_events;
    wire             sleep_sync;
    wire             sleep_change;
    // internal power-up level of the output-only pins
    wire [`OUT_PIN_COUNT-1:0] drive_reset;

    // two-flop view of the sleep level from the power controller
    // a sleep pulse under one clock may slip by; sleep is held far longer
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            sleep_s1_q   <= 1'b0;
            sleep_s2_q   <= 1'b0;
            sleep_prev_q <= 1'b0;
        end else begin
            sleep_s1_q   <= sleep_in;
            sleep_s2_q   <= sleep_s1_q;
            sleep_prev_q <= sleep_s2_q;
        end
    end
    assign sleep_sync   = sleep_s2_q;
    assign sleep_change = sleep_s2_q ^ sleep_prev_q;

    // edge detector keeps running in sleep so pins can wake the device
    pin_edge_detect #(
        .WIDTH       (NPIN)
    ) u_edge (
        .clock_in    (clock_in),
        .nrst_in     (nrst_in),
        .pin_in      (bidir_gp_pin_in),
        .rise_sel_in (rise_q),
        .level_out   (),
        .edge_out    (pin_edge)
    );

    // only input pins take enable/edge writes; peripheral ownership is no bar
    assign writable = pin_is_input_in; // [RULE_05] [RULE_06]

    // enable and edge update; clear wins enable ties, rising wins edge ties
    always @* begin
        wake_en_d = wake_en_q;
        rise_d    = rise_q;
        if (wake_en_wr_in) begin
            wake_en_d = (wake_en_q | (wake_set_mask_in & writable))      // [RULE_01] [RULE_02]
                        & ~(wake_clear_mask_in & writable);              // [RULE_03]
        end
        if (edge_wr_in) begin
            rise_d = (rise_q & ~(falling_edge_mask_in & writable))       // [RULE_04]
                     | (rising_edge_mask_in & writable);
        end
    end

    // sleep does not touch this state; only writes and reset (deep sleep) change it
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            wake_en_q <= `WAKE_EN_RESET;   // [RULE_21] [RULE_22]
            rise_q    <= `EDGE_RISE_RESET; // [RULE_04]
        end else begin
            wake_en_q <= wake_en_d;        // [RULE_07]
            rise_q    <= rise_d;
        end
    end

    // enabled input pins with the chosen edge raise events
    assign pin_event  = pin_edge & wake_en_q & pin_is_input_in; // [RULE_23]
    assign new_events = {other_event_in, pin_event};

    // sticky status; read clears, but an event in the read cycle survives
    always @* begin
        status_d = status_q | new_events;  // [RULE_12]
        if (status_rd_in) begin
            status_d = new_events;         // [RULE_09]
        end
    end

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            status_q        <= {NSTAT{1'b0}}; // [RULE_11]
            status_data_out <= 32'h00000000;
        end else begin
            status_q        <= status_d;
            if (status_rd_in) begin
                status_data_out <= {{(32-NSTAT){1'b0}}, status_q}; // [RULE_10]
            end
        end
    end
    assign wake_req_out    = |status_q[NPIN-1:0]; // [RULE_23]
    assign wake_en_out     = wake_en_q;
    assign edge_rising_out = rise_q;

    // radio/modem routing mode
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            route_q <= 1'b0;
        end else if (route_wr_in) begin
            route_q <= rf_signal_route_en_in; // [RULE_13]
        end
    end
    assign rf_signal_route_en_out = route_q;

    // registered pin drive; routing picks radio or normal sources
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            bidir_gp_pin_out      <= {NPIN{1'b0}};
            bidir_gp_pin_oe_n_out <= {NPIN{1'b1}};
        end else if (route_q) begin
            bidir_gp_pin_out      <= rf_out_in;   // [RULE_13]
            bidir_gp_pin_oe_n_out <= rf_oe_n_in;
        end else begin
            bidir_gp_pin_out      <= gp_out_in;
            bidir_gp_pin_oe_n_out <= gp_oe_n_in;
        end
    end

    // output-only pin ownership; refused while the spi master holds them
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            out_gp_en_q    <= 1'b0;                // [RULE_16]
            out_en_ack_out <= 1'b0;
            out_en_ok_out  <= 1'b0;
        end else begin
            out_en_ack_out <= out_en_wr_in;
            if (sleep_sync || sleep_change) begin
                out_gp_en_q <= 1'b0;               // [RULE_16]
                // pins stay released, so only a release request reports success
                if (out_en_wr_in) begin
                    out_en_ok_out <= ~out_en_val_in; // [RULE_16]
                end
            end else if (out_en_wr_in) begin
                if (out_en_val_in && spi_master_active_in) begin
                    out_en_ok_out <= 1'b0;         // [RULE_15]
                end else begin
                    out_gp_en_q   <= out_en_val_in;
                    out_en_ok_out <= 1'b1;
                end
            end
        end
    end
    assign out_gp_enabled_out = out_gp_en_q;
    // pull-ups forced on at all times, owned or released; no pull-up control here
    assign out_pullup_en_out  = `PULLUP_RESET;      // [RULE_16]
    assign drive_reset        = `DRIVE_RESET;       // [RULE_18]

    // drive level; low wins ties, blank bits keep level, owned pins wait
    // a second write before release replaces the pending value, not queued
    genvar k;
    generate
        for (k = 0; k < `OUT_PIN_COUNT; k = k + 1) begin : g_drive
            always @(posedge clock_in) begin
                if (!nrst_in) begin
                    drive_q[k]   <= drive_reset[k]; // [RULE_18]
                    pend_hi_q[k] <= 1'b0;
                    pend_lo_q[k] <= 1'b0;
                end else if (drive_wr_in && out_periph_en_in[k]) begin
                    pend_hi_q[k] <= drive_high_mask_in[k] & ~drive_low_mask_in[k]; // [RULE_20]
                    pend_lo_q[k] <= drive_low_mask_in[k];
                end else if (drive_wr_in) begin
                    pend_hi_q[k] <= 1'b0;
                    pend_lo_q[k] <= 1'b0;
                    if (drive_low_mask_in[k]) begin
                        drive_q[k] <= 1'b0;        // [RULE_17] [RULE_19]
                    end else if (drive_high_mask_in[k]) begin
                        drive_q[k] <= 1'b1;        // [RULE_17]
                    end
                end else if (!out_periph_en_in[k] && (pend_hi_q[k] || pend_lo_q[k])) begin
                    drive_q[k]   <= pend_hi_q[k];  // [RULE_20]
                    pend_hi_q[k] <= 1'b0;
                    pend_lo_q[k] <= 1'b0;
                end
            end
        end
    endgenerate

    // one pin's source: gp drive while owned, else spi, else diversity switch
    function pick_out_level;
        input gp_owned;
        input gp_level;
        input spi_busy;
        input spi_level;
        input div_level;
        begin
            if (gp_owned) begin
                pick_out_level = gp_level;
            end else if (spi_busy) begin
                pick_out_level = spi_level;
            end else begin
                pick_out_level = div_level;
            end
        end
    endfunction

    // gp ownership shuts out spi and diversity drive
    assign output_only_pin_zero_out = pick_out_level(out_gp_en_q,       // [RULE_14]
        drive_q[`OUT_PIN_ZERO_BIT], spi_master_active_in,
        spi_drive_in[`OUT_PIN_ZERO_BIT], diversity_drive_in[`OUT_PIN_ZERO_BIT]);
    assign output_only_pin_one_out  = pick_out_level(out_gp_en_q,       // [RULE_14]
        drive_q[`OUT_PIN_ONE_BIT], spi_master_active_in,
        spi_drive_in[`OUT_PIN_ONE_BIT], diversity_drive_in[`OUT_PIN_ONE_BIT]);
endmodule

//--- verif/gp_pin_source.sv
`timescale 1ns/1ps
// far side of the bidirectional pads: levels move well after the edge
module gp_pin_source #(
    parameter NPIN = 19
) (
    input  wire            clock_in,
    input  wire [NPIN-1:0] level_in,
    output reg  [NPIN-1:0] pin_out
);
    // late update so the synchroniser sees a truly asynchronous change
    initial pin_out = {NPIN{1'b0}};
    always @(posedge clock_in) begin
        pin_out <= #13 level_in;
    end
endmodule

//--- verif/pin_wake_checker.sv
`timescale 1ns/1ps
module pin_wake_checker #(
    parameter NPIN = 19
) (
    // clock, reset and inputs
    input wire            clock_in, nrst_in,
    input wire [NPIN-1:0] pin_is_input_in, wake_set_mask_in, wake_clear_mask_in,
    input wire [NPIN-1:0] rising_edge_mask_in, falling_edge_mask_in, bidir_gp_pin_in,
    input wire            wake_en_wr_in, edge_wr_in, status_rd_in, out_en_wr_in,
    input wire            out_en_val_in, spi_master_active_in, drive_wr_in,
    input wire [1:0]      spi_drive_in, drive_high_mask_in, drive_low_mask_in, out_periph_en_in,
    // watched outputs
    input wire [31:0]     status_data_out,
    input wire [NPIN-1:0] wake_en_out, edge_rising_out,
    input wire            wake_req_out, output_only_pin_zero_out, output_only_pin_one_out,
    input wire            out_gp_enabled_out, out_en_ack_out, out_en_ok_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // per-pin effect of one write; pins that are not inputs drop out
    wire [NPIN-1:0] en_set  = wake_set_mask_in & ~wake_clear_mask_in & pin_is_input_in;
    wire [NPIN-1:0] en_clr  = wake_clear_mask_in & pin_is_input_in;
    wire [NPIN-1:0] eg_hit  = (rising_edge_mask_in | falling_edge_mask_in) & pin_is_input_in;
    wire [NPIN-1:0] eg_rise = rising_edge_mask_in & pin_is_input_in;
    wire [1:0]      out_pins = {output_only_pin_one_out, output_only_pin_zero_out};

    a_wake_write: assert property (wake_en_wr_in |=> wake_en_out ==
        (($past(wake_en_out) & ~$past(en_clr)) | $past(en_set))) else $error("wake enable wrong");
    a_wake_keep: assert property (!wake_en_wr_in |=> $stable(wake_en_out))
        else $error("wake enable moved without a write");
    a_edge_write: assert property (edge_wr_in |=> edge_rising_out ==
        (($past(edge_rising_out) & ~$past(eg_hit)) | $past(eg_rise))) else $error("edge wrong");
    a_edge_keep: assert property (!edge_wr_in |=> $stable(edge_rising_out))
        else $error("edge select moved without a write");
    a_status_pad: assert property (status_data_out[31:21] == 11'h000)
        else $error("unused status bits not zero");
    a_pin_event: assert property ($rose(bidir_gp_pin_in[0]) && pin_is_input_in[0] &&
        wake_en_out[0] && edge_rising_out[0] |-> ##[1:8] (wake_req_out || status_rd_in))
        else $error("pin event raised no wake request");
    a_out_refuse: assert property (out_en_wr_in && out_en_val_in && spi_master_active_in
        |=> out_en_ack_out && !out_en_ok_out && $stable(out_gp_enabled_out))
        else $error("output enable granted while spi busy");
    a_out_grant: assert property (out_en_wr_in && out_en_val_in && !spi_master_active_in
        |=> out_en_ok_out && out_gp_enabled_out) else $error("output enable not granted");
    a_spi_pass: assert property (!out_gp_enabled_out && spi_master_active_in
        |-> out_pins == spi_drive_in) else $error("spi drive not on output pins");
    a_drive_write: assert property ((drive_wr_in && out_gp_enabled_out &&
        out_periph_en_in == 2'h0) ##1 out_gp_enabled_out |-> out_pins ==
        (($past(out_pins) | $past(drive_high_mask_in)) & ~$past(drive_low_mask_in)))
        else $error("output pin drive wrong");
endmodule

bind pin_wake_and_output_ctrl pin_wake_checker #(.NPIN(NPIN)) u_check (
    .clock_in, .nrst_in, .pin_is_input_in, .wake_set_mask_in, .wake_clear_mask_in,
    .rising_edge_mask_in, .falling_edge_mask_in, .bidir_gp_pin_in, .wake_en_wr_in, .edge_wr_in,
    .status_rd_in, .out_en_wr_in, .out_en_val_in, .spi_master_active_in, .drive_wr_in,
    .spi_drive_in, .drive_high_mask_in, .drive_low_mask_in, .out_periph_en_in, .status_data_out,
    .wake_en_out, .edge_rising_out, .wake_req_out, .output_only_pin_zero_out,
    .output_only_pin_one_out, .out_gp_enabled_out, .out_en_ack_out, .out_en_ok_out
);

//--- verif/test_pin_wake_and_output_ctrl.sv
`timescale 1ns/1ps
module test_pin_wake_and_output_ctrl;
    localparam N = 19;
    // stimulus, all defined at time zero; pin 5 is an output, pin 0 owned by a peripheral
    logic clock_in = 1'b0, nrst_in = 1'b0, wake_en_wr_in = 1'b0, edge_wr_in = 1'b0;
    logic status_rd_in = 1'b0, sleep_in = 1'b0, route_wr_in = 1'b0, rf_signal_route_en_in = 1'b0;
    logic out_en_wr_in = 1'b0, out_en_val_in = 1'b0, spi_master_active_in = 1'b0, drive_wr_in = 1'b0;
    logic [N-1:0] pin_is_input_in = 19'h7ffdf, pin_periph_owned_in = 19'h00001;
    logic [N-1:0] wake_set_mask_in = 19'h00000, wake_clear_mask_in = 19'h00000;
    logic [N-1:0] rising_edge_mask_in = 19'h00000, falling_edge_mask_in = 19'h00000;
    logic [N-1:0] rf_out_in = 19'h2aaaa, rf_oe_n_in = 19'h0f0f0, pin_level = 19'h00000;
    logic [N-1:0] gp_out_in = 19'h15555, gp_oe_n_in = 19'h7ffff;
    logic [1:0]   other_event_in = 2'h0, spi_drive_in = 2'h0, diversity_drive_in = 2'h3;
    logic [1:0]   drive_high_mask_in = 2'h0, drive_low_mask_in = 2'h0, out_periph_en_in = 2'h0;
    // design outputs and far-side pads
    wire [N-1:0] bidir_gp_pin_in, wake_en_out, edge_rising_out, bidir_gp_pin_out;
    wire [N-1:0] bidir_gp_pin_oe_n_out;
    wire [31:0]  status_data_out;
    wire [1:0]   out_pullup_en_out;
    wire         wake_req_out, rf_signal_route_en_out, output_only_pin_zero_out;
    wire         output_only_pin_one_out, out_gp_enabled_out, out_en_ack_out, out_en_ok_out;
    wire [1:0]   out_pins = {output_only_pin_one_out, output_only_pin_zero_out};
    int          err_total = 0;
    int          checked = 0;

    pin_wake_and_output_ctrl #(.NPIN(N)) DUT (
        .clock_in, .nrst_in, .pin_is_input_in, .pin_periph_owned_in, .wake_en_wr_in,
        .wake_set_mask_in, .wake_clear_mask_in, .edge_wr_in, .rising_edge_mask_in,
        .falling_edge_mask_in, .status_rd_in, .other_event_in, .sleep_in, .bidir_gp_pin_in,
        .route_wr_in, .rf_signal_route_en_in, .rf_out_in, .rf_oe_n_in, .gp_out_in, .gp_oe_n_in,
        .out_en_wr_in, .out_en_val_in, .spi_master_active_in, .spi_drive_in, .diversity_drive_in,
        .drive_wr_in, .drive_high_mask_in, .drive_low_mask_in, .out_periph_en_in,
        .status_data_out, .wake_req_out, .wake_en_out, .edge_rising_out, .bidir_gp_pin_out,
        .bidir_gp_pin_oe_n_out, .rf_signal_route_en_out, .output_only_pin_zero_out,
        .output_only_pin_one_out, .out_pullup_en_out, .out_gp_enabled_out, .out_en_ack_out,
        .out_en_ok_out
    );
    gp_pin_source #(.NPIN(N)) far_pins (.clock_in, .level_in(pin_level), .pin_out(bidir_gp_pin_in));

    // 20 MHz clock
    initial begin
        forever #25 clock_in = ~clock_in;
    end

    // inputs change 1 ns after the edge, well clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // write strobes end with an idle edge so a strobe never re-rises in one step
    task automatic wake_wr(input logic [N-1:0] s, input logic [N-1:0] c);
        wake_set_mask_in = s;
        wake_clear_mask_in = c;
        wake_en_wr_in = 1'b1;
        step(1);
        wake_en_wr_in = 1'b0;
        step(1);
    endtask
    task automatic edge_wr(input logic [N-1:0] r, input logic [N-1:0] f);
        rising_edge_mask_in = r;
        falling_edge_mask_in = f;
        edge_wr_in = 1'b1;
        step(1);
        edge_wr_in = 1'b0;
        step(1);
    endtask
    task automatic drive(input logic [1:0] h, input logic [1:0] l);
        drive_high_mask_in = h;
        drive_low_mask_in = l;
        drive_wr_in = 1'b1;
        step(1);
        drive_wr_in = 1'b0;
        step(1);
    endtask
    task automatic rd;
        status_rd_in = 1'b1;
        step(1);
        status_rd_in = 1'b0;
        step(1);
    endtask
    // ack stands one cycle, so it is looked at right after the taking edge
    task automatic out_req(input logic ok_exp);
        out_en_val_in = 1'b1;
        out_en_wr_in = 1'b1;
        step(1);
        chk(out_en_ack_out, 32'h1);
        chk(out_en_ok_out, ok_exp);
        out_en_wr_in = 1'b0;
        step(1);
    endtask
    task automatic route(input logic en, input logic [N-1:0] v, input logic [N-1:0] oe);
        rf_signal_route_en_in = en;
        route_wr_in = 1'b1;
        step(1);
        route_wr_in = 1'b0;
        step(1);
        chk(rf_signal_route_en_out, en);
        chk(bidir_gp_pin_out, v);
        chk(bidir_gp_pin_oe_n_out, oe);
    endtask

    task automatic t_reset;
        chk(wake_en_out, 32'h0);
        chk(edge_rising_out, 32'h7ffff);
        chk(status_data_out, 32'h0);
        chk(out_gp_enabled_out, 32'h0);
        chk(out_pullup_en_out, 32'h3);
    endtask
    task automatic t_masks;
        wake_wr(19'h0000f, 19'h00006);
        chk(wake_en_out, 32'h9);
        wake_wr(19'h00030, 19'h00000);
        chk(wake_en_out, 32'h19);
        edge_wr(19'h00021, 19'h00003);
        chk(edge_rising_out, 32'h7fffd);
        edge_wr(19'h00000, 19'h00000);
        chk(edge_rising_out, 32'h7fffd);
    endtask
    // two pin events and one extra flag pile up, then one read empties all
    task automatic t_status;
        pin_level = 19'h00011;
        other_event_in = 2'h2;
        step(1);
        other_event_in = 2'h0;
        step(8);
        chk(wake_req_out, 32'h1);
        rd();
        chk(status_data_out, 32'h00100011);
        chk(wake_req_out, 32'h0);
        rd();
        chk(status_data_out, 32'h0);
    endtask
    task automatic t_outputs;
        spi_master_active_in = 1'b1;
        out_req(1'b0);
        chk(out_gp_enabled_out, 32'h0);
        spi_master_active_in = 1'b0;
        out_req(1'b1);
        chk(out_pins, 32'h3);
        spi_master_active_in = 1'b1;
        step(1);
        chk(out_pins, 32'h3);
        spi_master_active_in = 1'b0;
        drive(2'h3, 2'h2);
        chk(out_pins, 32'h1);
        drive(2'h0, 2'h0);
        chk(out_pins, 32'h1);
        out_periph_en_in = 2'h1;
        drive(2'h0, 2'h1);
        chk(out_pins, 32'h1);
        out_periph_en_in = 2'h0;
        step(1);
        chk(out_pins, 32'h0);
        drive(2'h2, 2'h0);
        chk(out_pins, 32'h2);
    endtask
    // falling pads during sleep meet rising-edge pins, so no new event
    task automatic t_sleep;
        pin_level = 19'h00000;
        sleep_in = 1'b1;
        step(6);
        chk(out_gp_enabled_out, 32'h0);
        sleep_in = 1'b0;
        step(6);
        chk(wake_en_out, 32'h19);
        chk(edge_rising_out, 32'h7fffd);
        chk(out_gp_enabled_out, 32'h0);
        chk(out_pins, 32'h3);
    endtask
    // a full reset ends deep sleep and must leave no pin wake source behind
    task automatic t_deep_wake;
        pin_level = 19'h00011;
        step(8);
        chk(wake_req_out, 32'h1);
        nrst_in = 1'b0;
        step(3);
        nrst_in = 1'b1;
        chk(wake_en_out, 32'h0);
        chk(wake_req_out, 32'h0);
        rd();
        chk(status_data_out, 32'h0);
    endtask

    // main sequence
    initial begin
        step(12);
        nrst_in = 1'b1;
        t_reset();
        t_masks();
        t_status();
        t_outputs();
        t_sleep();
        t_deep_wake();
        route(1'b1, 19'h2aaaa, 19'h0f0f0);
        route(1'b0, 19'h15555, 19'h7ffff);
        wrap_up();
    end
    // watchdog, far beyond the roughly 76 cycles the run needs
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
endmodule
